/* File: src/ddrlv_pkg.sv */
package ddrlv_pkg;

    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [31:0] LVL_CFG_ADDR = 32'h0262_0460;
    localparam logic [31:0] LVL_CTRL_ADDR = 32'h2100_00dc;
    localparam logic [31:0] LVL_STAT_ADDR = 32'h2100_00e0;
    localparam logic [31:0] LVL_RATIO_ADDR = 32'h2100_00e4;

    // ==========================================================
    // field positions
    localparam int CFG_SAMPLE_LSB = 0;
    localparam int CFG_BYPASS_BIT = 9;
    localparam int CTRL_PRESC_LSB = 0;
    localparam int CTRL_EYE_IVL_LSB = 8;
    localparam int CTRL_WR_IVL_LSB = 16;
    localparam int CTRL_RATIO_BIT = 30;
    localparam int CTRL_TRIG_BIT = 31;
    localparam int RATIO_GATE_LSB = 0;
    localparam int RATIO_WL_LSB = 8;
    localparam int RATIO_EYE_LSB = 16;
    localparam int STAT_CNT_LSB = 8;
    localparam int STAT_TRAINED_LSB = 16;

    // ==========================================================
    // reset values and counts
    localparam logic [7:0] EYE_SAMPLE_RST = 8'h34;
    localparam logic [7:0] EVT_MIN = 8'h40;
    localparam logic [2:0] SETTLE_CYC = 3'h4;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        LV_IDLE, LV_WRLVL, LV_GATE, LV_EYE, LV_DONE
    } ddrlv_state_t;

    typedef struct packed {
        logic wl_start;
        logic gate_start;
        logic train_mode;
        logic ratio_force;
        logic incr_evt;
        logic [7:0] dqs_delay;
        logic [7:0] gate_delay;
        logic [7:0] wl_delay;
        logic [7:0] eye_point;
    } ddrlv_phy_t;

    typedef struct packed {
        ddrlv_state_t state;
        logic [7:0] eye_fixed;
        logic eye_bypass;
        logic [7:0] presc;
        logic [7:0] eye_ivl;
        logic [7:0] wr_ivl;
        logic ratio_mode;
        logic [7:0] gate_ratio;
        logic [7:0] wl_ratio;
        logic [7:0] eye_ratio;
        logic wr_pend;
        logic [31:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic [7:0] sweep;
        logic [2:0] settle;
        logic found;
        logic [7:0] first;
        logic [7:0] last;
        logic [7:0] trained;
        logic [7:0] presc_cnt;
        logic [7:0] ivl_cnt;
        logic [7:0] evt_cnt;
        logic traffic_ok;
        logic busy;
        logic eye_meta;
        logic eye_sync;
        logic hresp;
        ddrlv_phy_t phy;
    } ddrlv_regs_t;

endpackage

/* File: src/ddrlv_top.sv */
// Operation
// - wrlvl and gate training run automatically, followed by eye training unless bypassed
// - bypassed eye training uses the fixed programmed sample point
// - config bit 9 clear runs eye training, set bypasses it
// - config bits 7:0 hold the writable fixed eye sample value
// - fixed eye sample resets to 0x34, the recommended value
// - ratio-forced mode disables all auto leveling, uses register ratios
// - ratio values set gate, write and eye delays for all lanes
// - incremental read eye leveling exists only on revision 2.0
// - prescaler and eye interval fields in control set event spacing
// - eye training sets DRAM pattern mode and sweeps DQS delay
module ddrlv_top #(
    parameter bit REV2 = 1'b1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // phy handshake
    input wire logic phy_wl_done,
    input wire logic phy_gate_done,
    input wire logic eye_pass_pin,
    output ddrlv_pkg::ddrlv_phy_t phy,
    // memory traffic permission
    output logic traffic_ok,
    output logic lvl_busy
);
    import ddrlv_pkg::*;

    // ==========================================================
    // state
    ddrlv_regs_t r_reg;
    ddrlv_regs_t r_next;

    // ==========================================================
    // read decode
    function automatic logic [31:0] rd_mux(input ddrlv_regs_t s,
                                           input logic [31:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            LVL_CFG_ADDR: begin
                d[CFG_SAMPLE_LSB +: 8] = s.eye_fixed;
                d[CFG_BYPASS_BIT] = s.eye_bypass;
            end
            LVL_CTRL_ADDR: begin
                d[CTRL_PRESC_LSB +: 8] = s.presc;
                d[CTRL_EYE_IVL_LSB +: 8] = s.eye_ivl;
                d[CTRL_WR_IVL_LSB +: 8] = s.wr_ivl;
                d[CTRL_RATIO_BIT] = s.ratio_mode;
            end
            LVL_STAT_ADDR: begin
                d[0] = s.busy;
                d[1] = (s.state == LV_DONE);
                d[2] = s.traffic_ok;
                d[3] = s.found;
                d[STAT_CNT_LSB +: 8] = s.evt_cnt;
                d[STAT_TRAINED_LSB +: 8] = s.trained;
            end
            LVL_RATIO_ADDR: begin
                d[RATIO_GATE_LSB +: 8] = s.gate_ratio;
                d[RATIO_WL_LSB +: 8] = s.wl_ratio;
                d[RATIO_EYE_LSB +: 8] = s.eye_ratio;
            end
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic trig;
        logic wr_ok;
        logic incr_on;
        logic tick;
        trig = 1'b0;
        wr_ok = r_reg.wr_pend;
        incr_on = 1'b0;
        tick = 1'b0;
        r_next = r_reg;
        r_next.phy.wl_start = 1'b0;
        r_next.phy.gate_start = 1'b0;
        r_next.phy.incr_evt = 1'b0;
        // bus errors are never raised
        r_next.hresp = 1'b0;

        // pin synchroniser; only the second stage is read below
        r_next.eye_meta = eye_pass_pin;
        r_next.eye_sync = r_reg.eye_meta;

        // data phase of a write
        if (wr_ok) begin
            case (r_reg.wr_addr)
                LVL_CFG_ADDR: begin
                    r_next.eye_fixed = hwdata[CFG_SAMPLE_LSB +: 8];
                    r_next.eye_bypass = hwdata[CFG_BYPASS_BIT];
                end
                LVL_CTRL_ADDR: begin
                    r_next.presc = hwdata[CTRL_PRESC_LSB +: 8];
                    r_next.eye_ivl = hwdata[CTRL_EYE_IVL_LSB +: 8];
                    // held only; no incremental write leveling engine
                    r_next.wr_ivl = hwdata[CTRL_WR_IVL_LSB +: 8];
                    r_next.ratio_mode = hwdata[CTRL_RATIO_BIT];
                    trig = hwdata[CTRL_TRIG_BIT];
                end
                LVL_RATIO_ADDR: begin
                    r_next.gate_ratio = hwdata[RATIO_GATE_LSB +: 8];
                    r_next.wl_ratio = hwdata[RATIO_WL_LSB +: 8];
                    r_next.eye_ratio = hwdata[RATIO_EYE_LSB +: 8];
                end
                default: ;
            endcase
        end

        // address phase
        // only whole-word writes are stored; others are dropped
        r_next.wr_pend = hsel && htrans[1] && hready && hwrite &&
                         (hsize == HSIZE_WORD);
        if (hsel && htrans[1] && hready) begin
            r_next.wr_addr = haddr;
        end

        // leveling sequence
        case (r_reg.state)
            // a trigger during a run is dropped
            LV_IDLE, LV_DONE: begin
                if (trig) begin
                    r_next.evt_cnt = 8'h00;
                    r_next.presc_cnt = 8'h00;
                    r_next.ivl_cnt = 8'h00;
                    r_next.found = 1'b0;
                    // ratio mode skips every auto step
                    if (r_next.ratio_mode) begin
                        r_next.state = LV_DONE;
                    end else begin
                        r_next.state = LV_WRLVL;
                        r_next.phy.wl_start = 1'b1;
                    end
                end
            end
            LV_WRLVL: begin
                if (phy_wl_done) begin
                    // gate training follows on its own
                    r_next.state = LV_GATE;
                    r_next.phy.gate_start = 1'b1;
                end
            end
            LV_GATE: begin
                if (phy_gate_done) begin
                    if (r_reg.eye_bypass) begin
                        r_next.state = LV_DONE;
                    end else begin
                        r_next.state = LV_EYE;
                        r_next.phy.train_mode = 1'b1;
                        r_next.sweep = 8'h00;
                        r_next.settle = SETTLE_CYC - 3'h1;
                    end
                end
            end
            LV_EYE: begin
                // settle covers the pin synchroniser latency
                if (r_reg.settle != 3'h0) begin
                    r_next.settle = r_reg.settle - 3'h1;
                end else begin
                    // sweep dqs and record eye edges
                    if (r_reg.eye_sync) begin
                        if (!r_reg.found) begin
                            r_next.first = r_reg.sweep;
                        end
                        r_next.found = 1'b1;
                        r_next.last = r_reg.sweep;
                    end
                    if (r_reg.sweep == 8'hff) begin
                        r_next.state = LV_DONE;
                        r_next.phy.train_mode = 1'b0;
                        if (r_next.found) begin
                            r_next.trained = r_next.first +
                                ((r_next.last - r_next.first) >> 1);
                        end else begin
                            // no passing delay keeps the fixed sample
                            r_next.trained = r_reg.eye_fixed;
                        end
                    end else begin
                        r_next.sweep = r_reg.sweep + 8'h01;
                        r_next.settle = SETTLE_CYC - 3'h1;
                    end
                end
            end
            default: r_next.state = LV_IDLE;
        endcase

        // incremental leveling only on the newer revision
        incr_on = REV2 && (r_reg.state == LV_DONE) && !r_reg.ratio_mode &&
                  !r_reg.eye_bypass && (r_reg.eye_ivl != 8'h00);
        // prescaled interval counter, zero interval is off
        if (incr_on && !trig) begin
            tick = (r_reg.presc_cnt == r_reg.presc);
            r_next.presc_cnt = tick ? 8'h00 : r_reg.presc_cnt + 8'h01;
            if (tick) begin
                if (r_reg.ivl_cnt + 8'h01 == r_reg.eye_ivl) begin
                    r_next.ivl_cnt = 8'h00;
                    r_next.phy.incr_evt = 1'b1;
                    // saturate so a long run cannot wrap below the limit
                    if (r_reg.evt_cnt != 8'hff) begin
                        r_next.evt_cnt = r_reg.evt_cnt + 8'h01;
                    end
                end else begin
                    r_next.ivl_cnt = r_reg.ivl_cnt + 8'h01;
                end
            end
        end else if (!incr_on) begin
            r_next.presc_cnt = 8'h00;
            r_next.ivl_cnt = 8'h00;
        end

        // traffic held until done and, on REV2 without ratio mode or eye bypass, until enough events have run
        r_next.traffic_ok = (r_next.state == LV_DONE) &&
            (r_next.ratio_mode || r_next.eye_bypass || !REV2 ||
             r_next.evt_cnt >= EVT_MIN);
        r_next.busy = (r_next.state != LV_IDLE) &&
                      (r_next.state != LV_DONE);

        r_next.phy.ratio_force = r_next.ratio_mode &&
                                 (r_next.state == LV_DONE);
        // one value drives every byte lane
        r_next.phy.gate_delay = r_next.gate_ratio;
        r_next.phy.wl_delay = r_next.wl_ratio;
        if (r_next.phy.ratio_force) begin
            r_next.phy.eye_point = r_next.eye_ratio;
        end else if (r_next.eye_bypass) begin
            r_next.phy.eye_point = r_next.eye_fixed;
        end else begin
            r_next.phy.eye_point = r_next.trained;
        end
        r_next.phy.dqs_delay = r_next.phy.train_mode ? r_next.sweep :
                               r_next.phy.eye_point;

        // read data from next values so a write just ahead is seen
        r_next.hrdata = rd_mux(r_next, haddr);
        // no wait states: the slave is always ready
        r_next.hreadyout = 1'b1;
    end

    // ==========================================================
    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
            r_reg.eye_fixed <= EYE_SAMPLE_RST;
            r_reg.trained <= EYE_SAMPLE_RST;
            r_reg.phy.eye_point <= EYE_SAMPLE_RST;
            r_reg.phy.dqs_delay <= EYE_SAMPLE_RST;
            r_reg.state <= LV_IDLE;
            r_reg.hreadyout <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // outputs
    assign hreadyout = r_reg.hreadyout;
    assign hrdata = r_reg.hrdata;
    assign hresp = r_reg.hresp;
    assign phy = r_reg.phy;
    assign traffic_ok = r_reg.traffic_ok;
    assign lvl_busy = r_reg.busy;

    // ==========================================================
    // elaboration checks
    // each sweep step must outlast the two-stage pin synchroniser
    if (SETTLE_CYC < 3'h3) begin : g_settle_chk
        $error("settle time too short for the pin synchroniser");
    end

endmodule

/* File: testbench/ddrlv_top_monitor.sv */
module ddrlv_top_monitor
    import ddrlv_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // watched outputs
    input wire ddrlv_pkg::ddrlv_phy_t phy,
    input wire logic traffic_ok,
    input wire logic lvl_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // leveling sequence checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_wl_busy;
        phy.wl_start |=> lvl_busy;
    endproperty
    a_wl_busy: assert property (p_wl_busy)
        else $error("write leveling start without busy");
    property p_gate_alone;
        phy.gate_start |-> lvl_busy && !phy.train_mode;
    endproperty
    a_gate_alone: assert property (p_gate_alone)
        else $error("gate start overlaps eye sweep");
    property p_sweep_start;
        $rose(phy.train_mode) |-> phy.dqs_delay == 8'h00;
    endproperty
    a_sweep_start: assert property (p_sweep_start)
        else $error("sweep does not start at zero delay");
    property p_sweep_step;
        phy.train_mode && $past(phy.train_mode) && $changed(phy.dqs_delay)
            |-> phy.dqs_delay == $past(phy.dqs_delay) + 8'h01;
    endproperty
    a_sweep_step: assert property (p_sweep_step)
        else $error("sweep delay step is not one");
    property p_sweep_end;
        $fell(phy.train_mode) |-> ##[0:2] !lvl_busy;
    endproperty
    a_sweep_end: assert property (p_sweep_end)
        else $error("busy stays after sweep end");
    property p_ratio_quiet;
        phy.ratio_force |-> !(phy.train_mode || phy.wl_start
            || phy.gate_start || phy.incr_evt);
    endproperty
    a_ratio_quiet: assert property (p_ratio_quiet)
        else $error("auto leveling active in ratio mode");
    property p_evt_idle;
        phy.incr_evt |-> !lvl_busy && !phy.train_mode;
    endproperty
    a_evt_idle: assert property (p_evt_idle)
        else $error("incremental event during leveling");
    property p_traffic_idle;
        $rose(traffic_ok) |-> !lvl_busy;
    endproperty
    a_traffic_idle: assert property (p_traffic_idle)
        else $error("traffic allowed while leveling");
endmodule

bind ddrlv_top ddrlv_top_monitor u_mon (
    .hclk(hclk),
    .hresetn(hresetn),
    .phy(phy),
    .traffic_ok(traffic_ok),
    .lvl_busy(lvl_busy)
);

/* File: testbench/ddrlv_phy_model.sv */
module ddrlv_phy_model
    import ddrlv_pkg::*;
#(
    parameter logic [7:0] EYE_LO = 8'h40,
    parameter logic [7:0] EYE_HI = 8'h61
) (
    // clock and answer delay
    input wire logic hclk,
    input wire logic [3:0] lat,
    input wire ddrlv_pkg::ddrlv_phy_t phy,
    // responses
    output logic phy_wl_done,
    output logic phy_gate_done,
    output logic eye_pass_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int wl_cnt = -1;
    int gate_cnt = -1;
    logic noise = 1'b0;

    always @(posedge hclk) begin
        noise <= ~noise;
        phy_wl_done <= (wl_cnt == 0);
        phy_gate_done <= (gate_cnt == 0);
        wl_cnt <= phy.wl_start ? int'(lat) : (wl_cnt < 0 ? -1 : wl_cnt - 1);
        gate_cnt <= phy.gate_start ? int'(lat) :
            (gate_cnt < 0 ? -1 : gate_cnt - 1);
    end
    // good only inside the eye
    // outside a sweep the line is meaningless, so it toggles
    assign eye_pass_pin = phy.train_mode ?
        (phy.dqs_delay >= EYE_LO && phy.dqs_delay <= EYE_HI) : noise;
endmodule

/* File: testbench/tb_ddr3_leveling_init_control.sv */
module tb_ddr3_leveling_init_control;
    timeunit 1ns;
    timeprecision 1ps;
    import ddrlv_pkg::*;
    localparam logic [7:0] MID = 8'h50;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, traffic_ok, lvl_busy;
    logic [31:0] hrdata, rd;
    logic phy_wl_done, phy_gate_done, eye_pass_pin;
    ddrlv_phy_t phy;
    logic [3:0] lat = 4'h1;
    logic early_ok = 1'b0;
    logic seen_train = 1'b0;
    int errors = 0;
    int num_checks = 0;
    int evt_n = 0;
    int gap = 0;
    int last_cyc = 0;
    int cyc = 0;
    int n0;

    always #12.5 hclk = ~hclk;

    ddrlv_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .phy_wl_done(phy_wl_done),
        .phy_gate_done(phy_gate_done), .eye_pass_pin(eye_pass_pin),
        .phy(phy), .traffic_ok(traffic_ok), .lvl_busy(lvl_busy));
    ddrlv_phy_model #(.EYE_LO(8'h40), .EYE_HI(8'h61)) u_phy (.hclk(hclk),
        .lat(lat), .phy(phy), .phy_wl_done(phy_wl_done),
        .phy_gate_done(phy_gate_done), .eye_pass_pin(eye_pass_pin));

    // ==========================================================
    // observers and bus tasks
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (phy.train_mode === 1'b1) seen_train <= 1'b1;
        if (phy.incr_evt === 1'b1) begin
            evt_n <= evt_n + 1;
            gap <= cyc - last_cyc;
            last_cyc <= cyc;
        end
        // after training, permission comes with the 64th event at the soonest
        if (seen_train && traffic_ok === 1'b1 &&
            evt_n + int'(phy.incr_evt) < 64) early_ok <= 1'b1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wait_idle();
        repeat (3) @(posedge hclk);
        for (int i = 0; i < 3000 && lvl_busy !== 1'b0; i++) @(posedge hclk);
        chk(lvl_busy, 1'b0);
    endtask

    task automatic test_done();
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        test_done();
    end

    // ==========================================================
    // scenarios
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, LVL_CFG_ADDR, 32'h0);
        chk(rd, 32'h0000_0034);
        chk(hresp, 1'b0);
        bus(1'b0, 32'h0000_0ff0, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, LVL_CFG_ADDR, 32'h0000_025a);
        bus(1'b0, LVL_CFG_ADDR, 32'h0);
        chk(rd, 32'h0000_025a);
        // halfword writes are dropped
        hsize <= 3'h1;
        bus(1'b1, LVL_CFG_ADDR, 32'h0000_0011);
        hsize <= HSIZE_WORD;
        bus(1'b0, LVL_CFG_ADDR, 32'h0);
        chk(rd, 32'h0000_025a);
        bus(1'b1, LVL_CTRL_ADDR, 32'h8000_0000);
        wait_idle();
        chk(seen_train, 1'b0);
        chk(phy.eye_point, 8'h5a);
        chk(traffic_ok, 1'b1);
        lat <= 4'h9;
        bus(1'b1, LVL_CFG_ADDR, 32'h0000_0034);
        bus(1'b1, LVL_CTRL_ADDR, 32'h8000_0000);
        wait_idle();
        chk(seen_train, 1'b1);
        chk(phy.eye_point, MID);
        chk(traffic_ok, 1'b0);
        // idle, done, eye found, no events yet, trained point in 23:16
        bus(1'b0, LVL_STAT_ADDR, 32'h0);
        chk(rd, 32'h0050_000a);
        bus(1'b1, LVL_CTRL_ADDR, 32'h0000_0301);
        bus(1'b0, LVL_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0000_0301);
        for (int i = 0; i < 900 && evt_n < 64; i++) @(posedge hclk);
        chk(early_ok, 1'b0);
        chk(gap, 6);
        repeat (3) @(posedge hclk);
        chk(traffic_ok, 1'b1);
        bus(1'b1, LVL_CTRL_ADDR, 32'h0);
        repeat (3) @(posedge hclk);
        n0 = evt_n;
        repeat (40) @(posedge hclk);
        chk(evt_n, n0);
        chk(traffic_ok, 1'b1);
        bus(1'b1, LVL_RATIO_ADDR, 32'h0033_2211);
        bus(1'b1, LVL_CTRL_ADDR, 32'hc000_0000);
        repeat (4) @(posedge hclk);
        chk(phy.ratio_force, 1'b1);
        chk(phy.gate_delay, 8'h11);
        chk(phy.wl_delay, 8'h22);
        chk(phy.eye_point, 8'h33);
        chk(traffic_ok, 1'b1);
        bus(1'b0, LVL_RATIO_ADDR, 32'h0);
        chk(rd, 32'h0033_2211);
        test_done();
    end
endmodule
